/* File: hdl/imc_pkg.sv */
/*
 * constants for the timer-source interrupt mode control register.
 * assumes a 32-bit register port addressed by byte offset within the block.
 */
package imc_pkg;
	localparam logic [31:0] IMC_TIMER_OFS = 32'hFFFFE020;
	localparam logic [31:0] IMC_NEXT_OFS = 32'hFFFFE024;
	localparam logic [31:0] IRQ_STATUS_OFS = 32'hFFFFE100;
	localparam logic [31:0] IRQ_MASK_OFS = 32'hFFFFE104;
	localparam logic [31:0] EDGE_ERR_OFS = 32'hFFFFE108;
	// lane layout within one byte
	localparam int LEVEL_LSB = 0;
	localparam int DMA_BIT = 4;
	localparam int EDGE_LSB = 5;
	localparam logic [7:0] LANE_WMASK = 8'h77;
	localparam logic [1:0] EDGE_RISING = 2'h3;
	localparam logic [7:0] LANE_RESET = 8'h00;
	localparam logic [31:0] REG_RESET = 32'h00000000;
	localparam logic [2:0] LEVEL_DISABLED = 3'h0;
	localparam int NUM_SRC = 3;
	localparam int FIRST_LANE = 1;
	localparam logic [2:0] MASK_RESET = 3'h0;
endpackage : imc_pkg

/* File: hdl/imc_timer_group.sv */
/*
 * interrupt mode control for timer sources 33, 34 and 35 (upper three lanes
 * of one 32-bit register), plus sticky status, mask and an interrupt output.
 * assumes timer requests are synchronous to clk and a one-cycle strobe bus.
 */
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ns
module imc_timer_group (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [31:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic timer0_irq,
	input wire logic timer1_irq,
	input wire logic timer2_irq,
	output logic [2:0] cpu_irq_valid,
	output logic [8:0] cpu_irq_level,
	output logic [2:0] dma_trigger,
	output logic [8:0] dma_channel,
	output logic irq
);
	logic [31:0] int_mode_ctrl_timer_group_reg;
	logic [2:0] status_reg;
	logic [2:0] mask_reg;
	logic [2:0] req;
	logic [2:0] edge_bad;
	logic [2:0] event_set;
	logic [31:0] rdata_next;

	assign req = {timer2_irq, timer1_irq, timer0_irq};

	function automatic logic [7:0] lane_write(input logic [7:0] d);
		lane_write = d & imc_pkg::LANE_WMASK;
	endfunction : lane_write

	// low lane belongs to source 32 and is kept at reset value
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			int_mode_ctrl_timer_group_reg <= imc_pkg::REG_RESET;
		end else if (wr && addr == imc_pkg::IMC_TIMER_OFS) begin
			int_mode_ctrl_timer_group_reg[15:8] <= lane_write(wdata[15:8]);
			int_mode_ctrl_timer_group_reg[23:16] <= lane_write(wdata[23:16]);
			int_mode_ctrl_timer_group_reg[31:24] <= lane_write(wdata[31:24]);
		end
	end

	genvar g;
	generate
		for (g = 0; g < imc_pkg::NUM_SRC; g++) begin : g_lane
			src_lane u_lane (
				.clk(clk),
				.resetn(resetn),
				.lane(int_mode_ctrl_timer_group_reg[8*(g+imc_pkg::FIRST_LANE) +: 8]),
				.req(req[g]),
				.irq_valid(cpu_irq_valid[g]),
				.irq_level(cpu_irq_level[3*g +: 3]),
				.dma_trig(dma_trigger[g]),
				.dma_chan(dma_channel[3*g +: 3]),
				.edge_bad(edge_bad[g])
			);
		end
	endgenerate

	// events: a request forwarded to either the processor or dma
	assign event_set = cpu_irq_valid | dma_trigger;

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			status_reg <= imc_pkg::MASK_RESET;
		end else if (wr && addr == imc_pkg::IRQ_STATUS_OFS) begin
			status_reg <= (status_reg & ~wdata[2:0]) | event_set;
		end else begin
			status_reg <= status_reg | event_set;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mask_reg <= imc_pkg::MASK_RESET;
		end else if (wr && addr == imc_pkg::IRQ_MASK_OFS) begin
			mask_reg <= wdata[2:0];
		end
	end

	assign irq = |(status_reg & mask_reg);

	always_comb begin
		rdata_next = 32'h00000000;
		unique case (addr)
			imc_pkg::IMC_TIMER_OFS: rdata_next = int_mode_ctrl_timer_group_reg;
			imc_pkg::IRQ_STATUS_OFS: rdata_next = {29'h00000000, status_reg};
			imc_pkg::IRQ_MASK_OFS: rdata_next = {29'h00000000, mask_reg};
			imc_pkg::EDGE_ERR_OFS: rdata_next = {29'h00000000, edge_bad};
			default: rdata_next = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata <= 32'h00000000;
		end else if (rd) begin
			rdata <= rdata_next;
		end else begin
			rdata <= 32'h00000000;
		end
	end
endmodule : imc_timer_group

/* File: hdl/src_lane.sv */
/*
 * one interrupt source lane: edge detect on the timer request and routing
 * to the processor or to the dma controller.
 * assumes the timer request is synchronous to clk.
 */
`timescale 1ns/1ns
module src_lane (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] lane,
	input wire logic req,
	output logic irq_valid,
	output logic [2:0] irq_level,
	output logic dma_trig,
	output logic [2:0] dma_chan,
	output logic edge_bad
);
	logic req_d_reg;
	logic [2:0] field;
	logic dma_sel;
	logic rise;

	assign field = lane[imc_pkg::LEVEL_LSB +: 3];
	assign dma_sel = lane[imc_pkg::DMA_BIT];
	assign edge_bad = lane[imc_pkg::EDGE_LSB +: 2] != imc_pkg::EDGE_RISING;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			req_d_reg <= 1'b0;
		end else begin
			req_d_reg <= req;
		end
	end

	// only rising edges are honoured
	assign rise = req & ~req_d_reg;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_valid <= 1'b0;
			irq_level <= 3'h0;
			dma_trig <= 1'b0;
			dma_chan <= 3'h0;
		end else begin
			// level zero disables the processor request
			irq_valid <= rise & ~dma_sel & (field != imc_pkg::LEVEL_DISABLED);
			irq_level <= dma_sel ? 3'h0 : field;
			dma_trig <= rise & dma_sel;
			dma_chan <= dma_sel ? field : 3'h0;
		end
	end
endmodule : src_lane

/* File: test/imc_asserts.sv */
/* port checker for imc_timer_group; assumes bind from the bench */
`timescale 1ns/1ns
module imc_asserts (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [31:0] addr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic timer0_irq,
	input wire logic timer1_irq,
	input wire logic timer2_irq,
	input wire logic [2:0] cpu_irq_valid,
	input wire logic [8:0] cpu_irq_level,
	input wire logic [2:0] dma_trigger
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_src33_cause: assert property ((cpu_irq_valid[0] | dma_trigger[0]) |->
		$past(timer0_irq) && !$past(timer0_irq, 2)) else $error("src33 cause");
	a_src34_cause: assert property ((cpu_irq_valid[1] | dma_trigger[1]) |->
		$past(timer1_irq) && !$past(timer1_irq, 2)) else $error("src34 cause");
	a_src35_cause: assert property ((cpu_irq_valid[2] | dma_trigger[2]) |->
		$past(timer2_irq) && !$past(timer2_irq, 2)) else $error("src35 cause");
	a_route_excl: assert property ((cpu_irq_valid & dma_trigger) == 3'h0)
		else $error("both routes");
	a_level_nonzero: assert property (cpu_irq_valid[0] |-> cpu_irq_level[2:0] != 3'h0)
		else $error("level zero");
	a_single_pulse: assert property (cpu_irq_valid[0] |=> !cpu_irq_valid[0])
		else $error("long pulse");
	a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("rdata idle");
	a_unused_zero: assert property ($past(rd) && $past(addr) == imc_pkg::IMC_TIMER_OFS |->
		(rdata & 32'h888888FF) == 32'h0) else $error("unused bits");
endmodule : imc_asserts

/* File: test/tb.sv */
/* bench for imc_timer_group; assumes timer_model drives the timer requests */
`timescale 1ns/1ns
module tb;
	logic clk = 0, resetn = 0, wr = 0, rd = 0, irq;
	logic timer0_irq, timer1_irq, timer2_irq;
	logic [31:0] addr = 32'h0, wdata = 32'h0, rdata;
	logic [2:0] fire = 3'h0, cpu_irq_valid, dma_trigger;
	logic [8:0] cpu_irq_level, dma_channel;
	int n_fail = 0, comparisons = 0;
	always #20 clk = ~clk;
	timer_model tm (.clk(clk), .fire(fire), .tmr({timer2_irq, timer1_irq, timer0_irq}));
	imc_timer_group uut (
		.clk(clk),
		.resetn(resetn),
		.addr(addr),
		.wdata(wdata),
		.wr(wr),
		.rd(rd),
		.rdata(rdata),
		.timer0_irq(timer0_irq),
		.timer1_irq(timer1_irq),
		.timer2_irq(timer2_irq),
		.cpu_irq_valid(cpu_irq_valid),
		.cpu_irq_level(cpu_irq_level),
		.dma_trigger(dma_trigger),
		.dma_channel(dma_channel),
		.irq(irq)
	);
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task end_sim;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_sim
	task wr_reg(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		{wr, addr, wdata} <= {1'b1, a, d};
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wr_reg
	task rd_chk(input logic [31:0] a, input logic [31:0] exp);
		@(posedge clk);
		{rd, addr} <= {1'b1, a};
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask : rd_chk
	task fire_chk(input logic [31:0] cfg, input logic [2:0] f, input logic [23:0] e,
		input logic [31:0] sts);
		int i;
		wr_reg(imc_pkg::IMC_TIMER_OFS, cfg);
		@(posedge clk);
		fire <= f;
		@(posedge clk);
		fire <= 3'h0;
		for (i = 0; i < 8 && !(|{cpu_irq_valid, dma_trigger}); i++) @(posedge clk) #1;
		if (i == 8) begin
			n_fail++;
			end_sim;
		end
		chk({cpu_irq_valid, dma_trigger, cpu_irq_level, dma_channel}, e);
		rd_chk(imc_pkg::IRQ_STATUS_OFS, sts);
		chk(irq, 1'b0);
		wr_reg(imc_pkg::IRQ_MASK_OFS, 32'h7);
		chk(irq, 1'b1);
		wr_reg(imc_pkg::IRQ_STATUS_OFS, sts);
		chk(irq, 1'b0);
		wr_reg(imc_pkg::IRQ_MASK_OFS, 32'h0);
	endtask : fire_chk
	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		rd_chk(imc_pkg::IMC_TIMER_OFS, imc_pkg::REG_RESET);
		wr_reg(imc_pkg::IMC_TIMER_OFS, 32'hFFFFFFFF);
		rd_chk(imc_pkg::IMC_TIMER_OFS, 32'h77777700);
		rd_chk(32'h0, 32'h0);
		fire_chk(32'h60766500, 3'h7, {3'h1, 3'h2, 9'h005, 9'h030}, 32'h3);
		rd_chk(imc_pkg::EDGE_ERR_OFS, 32'h0);
		fire_chk(32'h67007300, 3'h5, {3'h4, 3'h1, 9'h1C0, 9'h003}, 32'h5);
		rd_chk(imc_pkg::EDGE_ERR_OFS, 32'h2);
		end_sim;
	end
endmodule : tb
bind imc_timer_group imc_asserts ac (.clk, .resetn, .addr, .rd, .rdata, .timer0_irq,
	.timer1_irq, .timer2_irq, .cpu_irq_valid, .cpu_irq_level, .dma_trigger);

/* File: test/timer_model.sv */
/* timer request sources; assumes one-cycle fire pulses from the bench */
`timescale 1ns/1ns
module timer_model (
	input wire logic clk,
	input wire logic [2:0] fire,
	output logic [2:0] tmr = 3'h0
);
	logic [2:0] hold = 3'h0;
	// two cycles high, then low before any new rise
	always_ff @(posedge clk) begin
		hold <= fire;
		tmr <= fire | hold;
	end
endmodule : timer_model
